// >>> core/drive_word_pkg.sv
// Shared constants for the drive command and status word logic
// Behaviour
// - Command bits 1:0 pick one of four presets
// - Bit 2 low brakes with DC, stops
// - Bit 3 low coasts, high permits start
// - Bit 4 low requests quick stop ramp
// - Bit 5 low freezes present output frequency
// - While frozen only coast or brake stop
// - Bit 6 low ramps down, high permits start
// - Trip reset only on bit 7 rising
// - Bit 8 high selects jog speed
// - Bit 9 picks ramp pair one or two
// - Bit 10 low: whole word ignored
// - Bits 11, 12 drive relays when selected
// - Bit 13 picks set-up when multi set-up
// - Bit 15 reverses only with bus sources
// - Bus bits gate with inputs per selection
// - Status 0-2: control, drive ready, enabled
// - Status 3,4,6,7 faults; bit 5 zero
// - Status 8: speed equals reference
// - Status 9: bus control accepted
// - Status 10 in limits, 11 operating
// - Status 12-15 temperature, voltage, torque, timer
// - Reference and frequency: 16384 is full scale
package drive_word_pkg;
  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int WORD_W = 16; // Command and status width
  localparam logic [15:0] CMD_RESET = 16'h0000; // Coasting after reset
  localparam int CB_REF_LSB = 0; // Preset index low bit
  localparam int CB_REF_MSB = 1; // Preset index high bit
  localparam int CB_RAMP_DC = 2; // Low means DC brake
  localparam int CB_NO_COAST = 3; // Low means coast
  localparam int CB_NO_QSTOP = 4; // Low means quick stop
  localparam int CB_USE_RAMP = 5; // Low means hold frequency
  localparam int CB_START = 6; // Low means ramp stop
  localparam int CB_RESET = 7; // Rising edge resets trip
  localparam int CB_JOG = 8; // Jog speed
  localparam int CB_RAMP2 = 9; // Second ramp pair
  localparam int CB_VALID = 10; // Word is valid
  localparam int CB_RELAY1 = 11; // Relay one
  localparam int CB_RELAY2 = 12; // Relay two
  localparam int CB_SETUP = 13; // Set-up choice
  localparam int CB_REVERSE = 15; // Reverse direction
  // ****************************************************************
  // Gating selections, shared by every combined function
  // ****************************************************************
  localparam logic [1:0] SEL_DIN = 2'h0; // Digital input only
  localparam logic [1:0] SEL_BUS = 2'h1; // Bus bit only
  localparam logic [1:0] SEL_AND = 2'h2; // Both must agree
  localparam logic [1:0] SEL_OR = 2'h3; // Either one
  // ****************************************************************
  // Scaling
  // ****************************************************************
  localparam logic [15:0] FULL_SCALE = 16'h4000; // 100 percent
  localparam int FULL_SCALE_SHIFT = 14; // log2 of full scale
endpackage : drive_word_pkg

// >>> core/drive_gate_select.sv
// Combines bus command bits with digital input functions
`timescale 1ns/1ps
module drive_gate_select #(
  parameter int WIDTH = 1 // Bits in the combined function
) (
  input wire logic [1:0] mode_in,
  input wire logic [WIDTH-1:0] bus_in,
  input wire logic [WIDTH-1:0] din_in,
  output logic [WIDTH-1:0] sel_out
);
  // ****************************************************************
  // Selection mux
  // ****************************************************************
  // Pure logic; the caller registers the result
  always_comb begin
    case (mode_in)
      drive_word_pkg::SEL_DIN: sel_out = din_in;
      drive_word_pkg::SEL_BUS: sel_out = bus_in;
      drive_word_pkg::SEL_AND: sel_out = bus_in & din_in;
      default: sel_out = bus_in | din_in;
    endcase
  end
endmodule : drive_gate_select

// >>> core/drive_ref_scaler.sv
// Scales a relative 16-bit reference to an absolute frequency
`timescale 1ns/1ps
module drive_ref_scaler (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [15:0] rel_in,
  input wire logic [15:0] full_in,
  output logic [15:0] abs_out
);
  // ****************************************************************
  // Multiply and saturate
  // ****************************************************************
  logic signed [31:0] prod; // Relative times full-scale frequency
  logic signed [31:0] shifted; // Divided by the 100 percent value
  logic [15:0] abs_d; // Saturated result
  // Full scale is a power of two, so a shift replaces a divider
  always_comb begin
    prod = $signed(rel_in) * $signed(full_in);
    shifted = prod >>> drive_word_pkg::FULL_SCALE_SHIFT;
    if (shifted > 32'sh00007FFF) begin
      abs_d = 16'h7FFF; // Clip high
    end else if (shifted < -32'sh00008000) begin
      abs_d = 16'h8000; // Clip low
    end else begin
      abs_d = shifted[15:0];
    end
  end
  // Registered output
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      abs_out <= 16'h0000;
    end else begin
      abs_out <= abs_d;
    end
  end
endmodule : drive_ref_scaler

// >>> core/drive_control_status_word_logic.sv
// Command word decoder and status word builder for the drive
`timescale 1ns/1ps
module drive_control_status_word_logic (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Telegram side, same clock
  input wire logic telegram_valid_in,
  input wire logic [15:0] command_word_in,
  input wire logic [15:0] speed_ref_in,
  // Settings, same clock
  input wire logic [1:0] preset_mode_in,
  input wire logic [1:0] coast_mode_in,
  input wire logic [1:0] start_mode_in,
  input wire logic [1:0] setup_mode_in,
  input wire logic [1:0] reverse_mode_in,
  input wire logic relay1_bus_sel_in,
  input wire logic relay2_bus_sel_in,
  input wire logic multi_setup_in,
  input wire logic [15:0] jog_speed_in,
  input wire logic [15:0] full_freq_in,
  // Digital input functions, from pins
  input wire logic [1:0] din_ref_sel_in,
  input wire logic din_no_coast_in,
  input wire logic din_start_in,
  input wire logic din_setup_in,
  input wire logic din_reverse_in,
  input wire logic din_dc_brake_in,
  // Drive state, same clock
  input wire logic control_ready_in,
  input wire logic drive_ready_in,
  input wire logic trip_in,
  input wire logic error_in,
  input wire logic trip_lock_in,
  input wire logic warning_in,
  input wire logic local_mode_in,
  input wire logic local_stop_in,
  input wire logic over_temp_stop_in,
  input wire logic dc_link_fault_in,
  input wire logic torque_limit_in,
  input wire logic thermal_timer_in,
  input wire logic [15:0] output_freq_in,
  input wire logic [15:0] low_limit_in,
  input wire logic [15:0] high_limit_in,
  // Decoded commands
  output logic [1:0] preset_index_out,
  output logic dc_brake_out,
  output logic coast_out,
  output logic quick_stop_out,
  output logic freeze_out,
  output logic ramp_stop_out,
  output logic run_enable_out,
  output logic trip_reset_out,
  output logic jog_out,
  output logic ramp_set_out,
  output logic relay1_out,
  output logic relay2_out,
  output logic setup_out,
  output logic reverse_out,
  output logic [15:0] speed_target_out,
  // Returned words
  output logic [15:0] drive_status_word_out,
  output logic [15:0] actual_output_frequency_value_out
);
  // Latency: word taken at the strobe edge, trip reset on that edge, other commands
  // one edge later, status one edge after that. Pins add two sync edges.
  // No stall exists; a word may follow every cycle.

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [6:0] din_meta_q; // First stage, read only by second
  logic [6:0] din_sync_q; // Safe to use
  logic [1:0] din_ref_s; // Synchronised preset index
  logic din_no_coast_s; // Synchronised no-coast
  logic din_start_s; // Synchronised start
  logic din_setup_s; // Synchronised set-up
  logic din_reverse_s; // Synchronised reverse
  logic din_dc_brake_s; // Synchronised DC brake
  // Pins are asynchronous; the first stage may go metastable,
  // so only the second stage feeds any logic below
  // Two flops for every pin input
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      din_meta_q <= 7'h00;
      din_sync_q <= 7'h00;
    end else begin
      din_meta_q <= {din_ref_sel_in, din_no_coast_in, din_start_in,
                     din_setup_in, din_reverse_in, din_dc_brake_in};
      din_sync_q <= din_meta_q;
    end
  end
  assign {din_ref_s, din_no_coast_s, din_start_s, din_setup_s,
          din_reverse_s, din_dc_brake_s} = din_sync_q;

  // ****************************************************************
  // Command word capture
  // ****************************************************************
  logic [15:0] cmd_q; // Last valid command word
  logic [15:0] ref_q; // Last valid speed reference
  logic trip_reset_q; // One-cycle reset pulse
  logic take_word; // Strobe with valid bit set
  // Words with the valid bit low carry only parameter traffic
  assign take_word = telegram_valid_in &&
                     command_word_in[drive_word_pkg::CB_VALID];
  // Capture in a single edge so outputs move together
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      cmd_q <= drive_word_pkg::CMD_RESET;
      ref_q <= 16'h0000;
    end else if (take_word) begin
      cmd_q <= command_word_in;
      ref_q <= speed_ref_in;
    end
  end

  // Only valid words move the edge reference, so a refused word
  // between two valid ones cannot fake or hide a reset edge
  // Reset edge is judged against the previously captured word
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      trip_reset_q <= 1'b0;
    end else begin
      trip_reset_q <= take_word &&
                      command_word_in[drive_word_pkg::CB_RESET] &&
                      !cmd_q[drive_word_pkg::CB_RESET];
    end
  end

  // ****************************************************************
  // Gating with digital inputs
  // ****************************************************************
  logic [1:0] ref_sel; // Combined preset index
  logic no_coast; // Combined no-coast
  logic start_sel; // Combined start
  logic setup_sel; // Combined set-up
  logic rev_sel; // Combined reverse

  // One selector per combined function; mode inputs are settings
  // on this clock and may change between words
  drive_gate_select #(.WIDTH(2)) u_ref_gate (
    .mode_in(preset_mode_in),
    .bus_in(cmd_q[drive_word_pkg::CB_REF_MSB:drive_word_pkg::CB_REF_LSB]),
    .din_in(din_ref_s),
    .sel_out(ref_sel)
  );

  drive_gate_select #(.WIDTH(1)) u_coast_gate (
    .mode_in(coast_mode_in),
    .bus_in(cmd_q[drive_word_pkg::CB_NO_COAST]),
    .din_in(din_no_coast_s),
    .sel_out(no_coast)
  );

  drive_gate_select #(.WIDTH(1)) u_start_gate (
    .mode_in(start_mode_in),
    .bus_in(cmd_q[drive_word_pkg::CB_START]),
    .din_in(din_start_s),
    .sel_out(start_sel)
  );

  drive_gate_select #(.WIDTH(1)) u_setup_gate (
    .mode_in(setup_mode_in),
    .bus_in(cmd_q[drive_word_pkg::CB_SETUP]),
    .din_in(din_setup_s),
    .sel_out(setup_sel)
  );

  // Default digital-input source leaves the bus bit without effect
  drive_gate_select #(.WIDTH(1)) u_rev_gate (
    .mode_in(reverse_mode_in),
    .bus_in(cmd_q[drive_word_pkg::CB_REVERSE]),
    .din_in(din_reverse_s),
    .sel_out(rev_sel)
  );
  // ****************************************************************
  // Stop and run commands
  // ****************************************************************
  logic frozen; // Hold requested
  assign frozen = !cmd_q[drive_word_pkg::CB_USE_RAMP];

  // Trade-off: registering the stops costs a cycle, but every
  // command output but trip reset then changes on the same edge
  // Stop paths; a frozen frequency blocks ramp and quick stops
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      dc_brake_out <= 1'b0;
      coast_out <= 1'b1;
      quick_stop_out <= 1'b0;
      freeze_out <= 1'b0;
      ramp_stop_out <= 1'b0;
      run_enable_out <= 1'b0;
    end else begin
      dc_brake_out <= !cmd_q[drive_word_pkg::CB_RAMP_DC] ||
                      din_dc_brake_s;
      coast_out <= !no_coast;
      freeze_out <= frozen;
      quick_stop_out <= !cmd_q[drive_word_pkg::CB_NO_QSTOP] &&
                        !frozen;
      ramp_stop_out <= !start_sel && !frozen;
      // Start needs every stop condition released
      run_enable_out <= no_coast && start_sel && !din_dc_brake_s &&
                        cmd_q[drive_word_pkg::CB_RAMP_DC] &&
                        cmd_q[drive_word_pkg::CB_NO_QSTOP];
    end
  end

  assign trip_reset_out = trip_reset_q;

  // ****************************************************************
  // Selections, relays and direction
  // ****************************************************************
  // Limitation: with multi set-up off the output does not fall
  // back to set-up 1; it keeps the last choice
  // Set-up holds its last value while multi set-up is off
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      preset_index_out <= 2'h0;
      jog_out <= 1'b0;
      ramp_set_out <= 1'b0;
      relay1_out <= 1'b0;
      relay2_out <= 1'b0;
      setup_out <= 1'b0;
      reverse_out <= 1'b0;
    end else begin
      preset_index_out <= ref_sel;
      jog_out <= cmd_q[drive_word_pkg::CB_JOG];
      ramp_set_out <= cmd_q[drive_word_pkg::CB_RAMP2];
      relay1_out <= relay1_bus_sel_in &&
                    cmd_q[drive_word_pkg::CB_RELAY1];
      relay2_out <= relay2_bus_sel_in &&
                    cmd_q[drive_word_pkg::CB_RELAY2];
      if (multi_setup_in) begin
        setup_out <= setup_sel;
      end
      reverse_out <= rev_sel;
    end
  end

  // ****************************************************************
  // Reference scaling
  // ****************************************************************
  // Jog replaces the bus reference; both are relative values
  logic [15:0] rel_src; // Jog speed or bus reference
  assign rel_src = cmd_q[drive_word_pkg::CB_JOG] ? jog_speed_in : ref_q;
  drive_ref_scaler u_scaler (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .rel_in(rel_src),
    .full_in(full_freq_in),
    .abs_out(speed_target_out)
  );

  // ****************************************************************
  // Status word
  // ****************************************************************
  logic [15:0] stat_d; // Next status word
  logic in_limits; // Frequency inside low and high limits
  logic freq_pos; // Frequency above zero
  // Strict compare: a frequency sitting on a limit reads as out
  assign in_limits = ($signed(output_freq_in) > $signed(low_limit_in)) &&
                     ($signed(output_freq_in) < $signed(high_limit_in));
  assign freq_pos = $signed(output_freq_in) > $signed(16'h0000);

  // Bit 5 is reserved and stays zero
  always_comb begin
    stat_d = 16'h0000;
    stat_d[0] = control_ready_in;
    stat_d[1] = drive_ready_in;
    stat_d[2] = !coast_out;
    stat_d[3] = trip_in;
    stat_d[4] = error_in;
    stat_d[6] = trip_lock_in;
    stat_d[7] = warning_in;
    stat_d[8] = output_freq_in == rel_src;
    stat_d[9] = !local_mode_in && !local_stop_in;
    stat_d[10] = in_limits;
    stat_d[11] = run_enable_out || freq_pos;
    stat_d[12] = over_temp_stop_in;
    stat_d[13] = dc_link_fault_in;
    stat_d[14] = torque_limit_in;
    stat_d[15] = thermal_timer_in;
  end

  // Status and returned frequency, one register stage
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      drive_status_word_out <= 16'h0000;
      actual_output_frequency_value_out <= 16'h0000;
    end else begin
      drive_status_word_out <= stat_d;
      actual_output_frequency_value_out <= output_freq_in;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  a_ref_bus_path: assert property (
    take_word && preset_mode_in == drive_word_pkg::SEL_BUS
    ##1 preset_mode_in == drive_word_pkg::SEL_BUS
    |=> preset_index_out == $past(command_word_in[1:0], 2))
    else $error("preset index not from bus word");

  a_dc_brake_on: assert property (
    !cmd_q[drive_word_pkg::CB_RAMP_DC] |=> dc_brake_out && !run_enable_out)
    else $error("DC brake not applied");

  a_din_brake: assert property (
    din_dc_brake_s |=> dc_brake_out && !run_enable_out)
    else $error("brake input did not stop");

  a_coast_stop: assert property (
    !no_coast |=> coast_out && !run_enable_out
    ##1 !drive_status_word_out[2])
    else $error("coast did not stop output");

  a_quick_stop: assert property (
    !cmd_q[drive_word_pkg::CB_NO_QSTOP] && !frozen |=> quick_stop_out)
    else $error("quick stop missing");

  a_freeze_guard: assert property (
    freeze_out |-> !ramp_stop_out && !quick_stop_out)
    else $error("ramp stop while frozen");

  a_reset_edge: assert property (
    trip_reset_out |-> cmd_q[drive_word_pkg::CB_RESET] &&
    !$past(cmd_q[drive_word_pkg::CB_RESET]) ##1 !trip_reset_out)
    else $error("trip reset without rising edge");

  a_invalid_ignored: assert property (
    telegram_valid_in && !command_word_in[drive_word_pkg::CB_VALID]
    |=> $stable(cmd_q) && !trip_reset_out)
    else $error("invalid word was used");

  a_relay_gate: assert property (
    relay1_out |-> $past(relay1_bus_sel_in) &&
    $past(cmd_q[drive_word_pkg::CB_RELAY1]))
    else $error("relay one without selection");

  a_rev_default: assert property (
    reverse_mode_in == drive_word_pkg::SEL_DIN |=>
    reverse_out == $past(din_reverse_s))
    else $error("reverse not from input");

  a_status_speed: assert property (
    drive_status_word_out[8] |-> $past(output_freq_in) == $past(rel_src))
    else $error("speed flag wrong");

  c_trip_reset: cover property (trip_reset_out);
  c_freeze_hold: cover property (freeze_out ##1 freeze_out);
  c_jog_run: cover property (jog_out && run_enable_out);
  c_refused_word: cover property (telegram_valid_in && !take_word);
  c_relay_pair: cover property (relay1_out && relay2_out);
endmodule : drive_control_status_word_logic

// >>> test/drive_master_model.sv
// Serial bus master model that hands telegrams to the drive logic
`timescale 1ns/1ps
module drive_master_model (
  input wire logic mclk_in,
  output logic telegram_valid_out,
  output logic [15:0] command_word_out,
  output logic [15:0] speed_ref_out
);
  // ********************
  // Idle lines
  // ********************
  // Lines carry junk between telegrams, never the last word sent
  initial begin
    telegram_valid_out = 1'b0;
    command_word_out = 16'hA5A5;
    speed_ref_out = 16'h5A5A;
  end
  // ********************
  // Telegram hand-over
  // ********************
  // Strobe lasts one cycle, launched and dropped off the falling edge
  task automatic send(input logic [15:0] word, input logic [15:0] ref_v);
    @(negedge mclk_in);
    telegram_valid_out = 1'b1;
    command_word_out = word;
    speed_ref_out = ref_v; // Two's complement, 16'h4000 full scale
    @(negedge mclk_in);
    // Scramble so a late sample never sees a stale word
    telegram_valid_out = 1'b0;
    command_word_out = ~word;
    speed_ref_out = ~ref_v;
  endtask : send
endmodule : drive_master_model

// >>> test/drive_control_status_word_logic_tb_top.sv
// Self-checking bench for the command decoder and status word builder
`timescale 1ns/1ps
module drive_control_status_word_logic_tb_top;
  // ********************
  // Signals, named as the ports
  // ********************
  logic mclk_in, rst_b_in, telegram_valid_in;
  logic [15:0] command_word_in, speed_ref_in, jog_speed_in, full_freq_in;
  logic [1:0] preset_mode_in, coast_mode_in, start_mode_in, setup_mode_in;
  logic [1:0] reverse_mode_in, din_ref_sel_in;
  logic relay1_bus_sel_in, relay2_bus_sel_in, multi_setup_in;
  logic din_no_coast_in, din_start_in, din_setup_in, din_reverse_in;
  logic din_dc_brake_in;
  logic [11:0] st; // Drive state flags, packed
  wire logic control_ready_in, drive_ready_in, trip_in, error_in;
  wire logic trip_lock_in, warning_in, local_mode_in, local_stop_in;
  wire logic over_temp_stop_in, dc_link_fault_in, torque_limit_in;
  wire logic thermal_timer_in;
  logic [15:0] output_freq_in, low_limit_in, high_limit_in;
  logic [1:0] preset_index_out;
  logic dc_brake_out, coast_out, quick_stop_out, freeze_out, ramp_stop_out;
  logic run_enable_out, trip_reset_out, jog_out, ramp_set_out, relay1_out;
  logic relay2_out, setup_out, reverse_out;
  logic [15:0] speed_target_out, drive_status_word_out;
  logic [15:0] actual_output_frequency_value_out;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  // Bench's own view of the last taken word
  logic [15:0] cw = 16'h0000, cref = 16'h0000;
  logic pb7 = 1'b0, sq = 1'b0;
  logic [13:0] ev = 14'h0400; // Expected command outputs
  assign {thermal_timer_in, torque_limit_in, dc_link_fault_in,
    over_temp_stop_in, local_stop_in, local_mode_in, warning_in,
    trip_lock_in, error_in, trip_in, drive_ready_in, control_ready_in} = st;
  wire logic [13:0] obs = {preset_index_out, dc_brake_out, coast_out,
    quick_stop_out, freeze_out, ramp_stop_out, run_enable_out, jog_out,
    ramp_set_out, relay1_out, relay2_out, setup_out, reverse_out};
  drive_control_status_word_logic uut (
    .mclk_in, .rst_b_in, .telegram_valid_in, .command_word_in,
    .speed_ref_in, .preset_mode_in, .coast_mode_in, .start_mode_in,
    .setup_mode_in, .reverse_mode_in, .relay1_bus_sel_in,
    .relay2_bus_sel_in, .multi_setup_in, .jog_speed_in, .full_freq_in,
    .din_ref_sel_in, .din_no_coast_in, .din_start_in, .din_setup_in,
    .din_reverse_in, .din_dc_brake_in, .control_ready_in, .drive_ready_in,
    .trip_in, .error_in, .trip_lock_in, .warning_in, .local_mode_in,
    .local_stop_in, .over_temp_stop_in, .dc_link_fault_in,
    .torque_limit_in, .thermal_timer_in, .output_freq_in, .low_limit_in,
    .high_limit_in, .preset_index_out, .dc_brake_out, .coast_out,
    .quick_stop_out, .freeze_out, .ramp_stop_out, .run_enable_out,
    .trip_reset_out, .jog_out, .ramp_set_out, .relay1_out, .relay2_out,
    .setup_out, .reverse_out, .speed_target_out, .drive_status_word_out,
    .actual_output_frequency_value_out);
  drive_master_model master (.mclk_in,
    .telegram_valid_out(telegram_valid_in),
    .command_word_out(command_word_in), .speed_ref_out(speed_ref_in));
  // ********************
  // Clock and hang guard
  // ********************
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  // Whole run needs under two hundred cycles; ceiling leaves wide margin
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ********************
  // Expectation helpers
  // ********************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // Bus bit combined with its pin function
  function automatic logic gate(input logic [1:0] m, input logic d, b);
    case (m)
      drive_word_pkg::SEL_DIN: return d;
      drive_word_pkg::SEL_BUS: return b;
      drive_word_pkg::SEL_AND: return d & b;
      default: return d | b;
    endcase
  endfunction : gate
  function automatic logic [13:0] exp_cmd(input logic [15:0] w);
    logic nc, go, fz;
    nc = gate(coast_mode_in, din_no_coast_in, w[3]);
    go = gate(start_mode_in, din_start_in, w[6]);
    fz = !w[5]; // Freeze masks quick and ramp stop only
    return {gate(preset_mode_in, din_ref_sel_in[1], w[1]),
      gate(preset_mode_in, din_ref_sel_in[0], w[0]),
      !w[2] | din_dc_brake_in, !nc,
      !w[4] & !fz, fz, !go & !fz, nc & go & w[2] & w[4] & !din_dc_brake_in,
      w[8], w[9], relay1_bus_sel_in & w[11], relay2_bus_sel_in & w[12],
      sq, gate(reverse_mode_in, din_reverse_in, w[15])};
  endfunction : exp_cmd
  function automatic logic [15:0] exp_sw();
    logic [15:0] f, rf;
    f = output_freq_in;
    rf = ev[5] ? jog_speed_in : cref; // Jog replaces the reference
    return {st[11:8], ($signed(f) > 0) | ev[6],
      ($signed(f) > $signed(low_limit_in)) &&
      ($signed(f) < $signed(high_limit_in)), !(st[6] | st[7]), f == rf,
      st[5:4], 1'b0, st[3:2], !ev[10], st[1:0]};
  endfunction : exp_sw
  // Saturating rel * full >>> 14
  function automatic logic [15:0] scale(input logic [15:0] r);
    logic signed [31:0] p;
    p = ($signed(r) * $signed(full_freq_in)) >>> 14;
    if (p > 32767) return 16'h7FFF;
    if (p < -32768) return 16'h8000;
    return p[15:0];
  endfunction : scale
  // One telegram, then every answer judged at its own cycle
  task automatic cmd(input logic [15:0] w, input logic [15:0] r = 16'h4000);
    master.send(w, r);
    chk({15'h0, trip_reset_out}, {15'h0, w[10] & w[7] & !pb7});
    if (w[10]) begin
      cw = w;
      cref = r;
      pb7 = w[7];
    end
    if (multi_setup_in) begin
      sq = gate(setup_mode_in, din_setup_in, cw[13]);
    end
    ev = exp_cmd(cw);
    @(negedge mclk_in);
    chk({2'h0, obs}, {2'h0, ev});
    chk(speed_target_out, scale(ev[5] ? jog_speed_in : cref));
    @(negedge mclk_in);
    chk(drive_status_word_out, exp_sw());
  endtask : cmd
  // ********************
  // Scenarios
  // ********************
  task automatic t_decode();
    logic [15:0] wv [6] = '{16'h0400, 16'h04FF, 16'hAF7D, 16'hDEB6,
      16'h07FE, 16'hF4A3};
    foreach (wv[j]) begin
      cmd(wv[j]);
    end
  endtask : t_decode
  task automatic t_status();
    logic [15:0] fv [5] = '{16'h0400, 16'h0401, 16'h3000, 16'h4000,
      16'hF000};
    for (int i = 0; i < 12; i++) begin
      st = 12'(1 << i);
      repeat (2) @(negedge mclk_in);
      chk(drive_status_word_out, exp_sw());
    end
    st = 12'h003;
    foreach (fv[j]) begin
      output_freq_in = fv[j];
      repeat (2) @(negedge mclk_in);
      chk(drive_status_word_out, exp_sw());
      chk(actual_output_frequency_value_out, fv[j]);
    end
  endtask : t_status
  // Refused word carries a reset edge that must not act
  task automatic t_invalid();
    cmd(16'h0474, 16'h2000);
    cmd(16'hB8FB, 16'h3000);
    cmd(16'h07F4, 16'h1000);
  endtask : t_invalid
  task automatic t_gate();
    relay1_bus_sel_in = 1'b0;
    relay2_bus_sel_in = 1'b0;
    multi_setup_in = 1'b0;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        {preset_mode_in, coast_mode_in, start_mode_in} = {3{2'(m)}};
        {setup_mode_in, reverse_mode_in} = {2{2'(m)}};
        {din_no_coast_in, din_start_in, din_setup_in} = {3{k[0]}};
        din_reverse_in = k[0];
        din_ref_sel_in = {k[0], k[1]};
        cmd(k[1] ? 16'hBC7F : 16'h0434);
      end
    end
    relay1_bus_sel_in = 1'b1;
    relay2_bus_sel_in = 1'b1;
    multi_setup_in = 1'b1;
    din_dc_brake_in = 1'b1; // Pin brake must still stop the drive
    cmd(16'hBC7F);
    din_dc_brake_in = 1'b0;
  endtask : t_gate
  task automatic t_scale();
    logic [15:0] rv [5] = '{16'h4000, 16'hC000, 16'h7FFF, 16'h8000,
      16'h0001};
    full_freq_in = 16'h7000; // Large so both rails saturate
    foreach (rv[j]) begin
      cmd(16'h0474, rv[j]);
    end
    cmd(16'h0574, 16'h1234);
  endtask : t_scale
  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks: %0d, mismatches: %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  // ********************
  // Main sequence
  // ********************
  initial begin
    rst_b_in = 1'b0;
    {preset_mode_in, coast_mode_in, start_mode_in} = {3{2'h1}};
    {setup_mode_in, reverse_mode_in} = {2{2'h1}};
    {relay1_bus_sel_in, relay2_bus_sel_in, multi_setup_in} = 3'h7;
    {din_no_coast_in, din_start_in, din_setup_in} = 3'h0;
    {din_reverse_in, din_dc_brake_in, din_ref_sel_in} = 4'h0;
    jog_speed_in = 16'h2000;
    full_freq_in = 16'h1F40;
    st = 12'h003;
    output_freq_in = 16'h0000;
    low_limit_in = 16'h0400;
    high_limit_in = 16'h3000;
    repeat (16) @(negedge mclk_in);
    chk({2'h0, obs}, 16'h0400);
    chk(drive_status_word_out, 16'h0000);
    rst_b_in = 1'b1;
    t_decode();
    t_status();
    t_invalid();
    t_gate();
    t_scale();
    end_of_test();
  end
endmodule : drive_control_status_word_logic_tb_top
